/* core/sfs_supervisor.sv */
// Fault supervisor: holdoff timer, trip control, mistake and event registers
`timescale 1ns/10ps
`default_nettype none

module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              holdoff_set_stb,
  input  wire logic [MS_W-1:0]   holdoff_set_val,
  input  wire logic              holdoff_readback_query,
  input  wire logic              voltage_program_cmd,
  input  wire logic              current_program_cmd,
  input  wire logic              sync_apply_cmd,
  input  wire logic              rearm_cmd,
  input  wire logic              output_on_cmd,
  input  wire logic              output_off_cmd,
  input  wire logic              trip_mode_set_stb,
  input  wire logic [1:0]        trip_mode_val,
  input  wire logic              suppress_set_stb,
  input  wire logic [EVT_W-1:0]  suppress_val,
  input  wire logic              mistake_stb,
  input  wire logic [7:0]        mistake_code,
  input  wire logic              line_end_stb,
  input  wire logic              sticky_status_query,
  input  wire logic              last_mistake_query,
  input  wire logic              event_query,
  input  wire logic              constant_voltage_state,
  input  wire logic              constant_current_state,
  output logic                   resp_valid_ff,
  output logic [MS_W-1:0]        resp_data_ff,
  output logic                   error_led_ff,
  output logic                   user_event_ff,
  output logic                   output_enable_ff,
  output logic                   tripped_ff,
  output logic                   discard_line_ff,
  output logic [1:0]             trip_mode_ff,
  output logic                   holdoff_active_ff
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic                volt_meta_ff;
  logic                volt_sync_ff;
  logic                curr_meta_ff;
  logic                curr_sync_ff;
  logic [PRESC_W-1:0]  presc_ff;
  logic [HOLD_W-1:0]   remain_ff;
  logic [HOLD_W-1:0]   holdoff_ticks_ff;
  logic [EVT_W-1:0]    suppress_ff;
  logic [EVT_W-1:0]    event_ff;
  logic [EVT_W-1:0]    sticky_ff;
  logic [7:0]          last_code_ff;

  // ----------------------------------------------------------------------
  // Command gating
  // ----------------------------------------------------------------------
  // Everything after a mistake on the same line is dropped
  wire go           = ~discard_line_ff;
  wire hs_go        = holdoff_set_stb & go;
  wire tm_go        = trip_mode_set_stb & go;
  wire rearm_go     = rearm_cmd & go;
  wire on_go        = output_on_cmd & go;
  wire off_go       = output_off_cmd & go;
  wire ext_mis      = mistake_stb & go;
  wire q_hold       = holdoff_readback_query & go;
  wire q_last       = last_mistake_query & go;
  wire q_event      = event_query & go;
  wire q_sticky     = sticky_status_query & go;
  wire range_bad    = hs_go & (holdoff_set_val > HOLDOFF_MAX_MS);
  wire mode_bad     = tm_go & (trip_mode_val == TRIP_BAD);
  wire hs_ok        = hs_go & ~range_bad;
  wire tm_ok        = tm_go & ~mode_bad;
  wire mistake_evt  = ext_mis | range_bad | mode_bad;
  wire [7:0] mis_num = ext_mis   ? mistake_code  :
                       range_bad ? MISTAKE_RANGE : MISTAKE_MODE;

  // ----------------------------------------------------------------------
  // Holdoff timer
  // ----------------------------------------------------------------------
  // Qualifying commands restart the interval, even mid-interval
  wire restart = go & (voltage_program_cmd | current_program_cmd |
                       sync_apply_cmd | rearm_cmd | output_on_cmd);
  wire tick    = (presc_ff == PRESC_W'(TICK_CYCLES - 1));
  wire run     = (remain_ff != '0);
  wire [PRESC_W-1:0] nxt_presc = (restart | tick) ? '0 :
                                 presc_ff + PRESC_W'(1);
  wire [HOLD_W-1:0]  nxt_remain =
    restart      ? holdoff_ticks_ff :
    (tick & run) ? remain_ff - HOLD_W'(1) : remain_ff;
  // Value in ms, quantised down to whole 32 ms ticks
  wire [HOLD_W-1:0]  set_ticks = HOLD_W'(holdoff_set_val >> TICK_SHIFT);

  // ----------------------------------------------------------------------
  // Trip and faults
  // ----------------------------------------------------------------------
  // Level check after holdoff so brief mode flips during a change are ignored
  wire trip_now = ~run & output_enable_ff &
                  (((trip_mode_ff == TRIP_VOLT) & volt_sync_ff) |
                   ((trip_mode_ff == TRIP_CURR) & curr_sync_ff));
  wire [EVT_W-1:0] fault_raw = {mistake_evt, trip_now,
                                curr_sync_ff & ~run, volt_sync_ff & ~run};
  wire [EVT_W-1:0] evt_set   = fault_raw & ~suppress_ff;
  // Set wins over the query clear in the same cycle
  wire [EVT_W-1:0] nxt_event = (q_event ? '0 : event_ff) | evt_set;
  wire mis_set = mistake_evt & ~suppress_ff[EVT_MIS];
  wire [EVT_W-1:0] live_sts  = {1'b0, tripped_ff, curr_sync_ff, volt_sync_ff};
  wire [EVT_W-1:0] sticky_base = q_sticky ? '0 :
                     (sticky_ff & ~(EVT_W'(q_last) << EVT_MIS));
  wire [EVT_W-1:0] nxt_sticky =
    sticky_base | live_sts | (EVT_W'(mis_set) << EVT_MIS);

  // ----------------------------------------------------------------------
  // Output enable
  // ----------------------------------------------------------------------
  // Trip wins over rearm; output-on cannot override a trip
  wire nxt_tripped = trip_now | (tripped_ff & ~rearm_go);
  wire nxt_out_en  = trip_now ? 1'b0 :
                     rearm_go ? 1'b1 :
                     off_go   ? 1'b0 :
                     on_go    ? ~tripped_ff : output_enable_ff;
  wire nxt_discard = (mistake_evt & ~line_end_stb) |
                     (discard_line_ff & ~line_end_stb);

  // ----------------------------------------------------------------------
  // Query answers, one at a time by fixed priority
  // ----------------------------------------------------------------------
  wire any_query = q_hold | q_last | q_event | q_sticky;
  wire [MS_W-1:0] nxt_resp =
    q_hold  ? {1'b0, holdoff_ticks_ff, 5'h00} :
    q_last  ? {8'h00, last_code_ff} :
    q_event ? MS_W'(event_ff) :
              MS_W'(sticky_ff | live_sts);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    volt_meta_ff <= constant_voltage_state;
    volt_sync_ff <= volt_meta_ff;
    curr_meta_ff <= constant_current_state;
    curr_sync_ff <= curr_meta_ff;
  end

  // ----------------------------------------------------------------------
  // Timer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presc_ff          <= '0;
      remain_ff         <= '0;
      holdoff_active_ff <= 1'b0;
    end else begin
      presc_ff          <= nxt_presc;
      remain_ff         <= nxt_remain;
      holdoff_active_ff <= (nxt_remain != '0);
    end
  end

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      holdoff_ticks_ff <= HOLDOFF_RST_TICKS;
      trip_mode_ff     <= TRIP_OFF;
      suppress_ff      <= SUPPRESS_RST;
    end else begin
      if (hs_ok) holdoff_ticks_ff <= set_ticks;
      if (tm_ok) trip_mode_ff <= trip_mode_val;
      if (suppress_set_stb & go) suppress_ff <= suppress_val;
    end
  end

  // ----------------------------------------------------------------------
  // Fault, mistake and output state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_ff         <= '0;
      user_event_ff    <= 1'b0;
      sticky_ff        <= '0;
      last_code_ff     <= MISTAKE_NONE;
      error_led_ff     <= 1'b0;
      discard_line_ff  <= 1'b0;
      tripped_ff       <= 1'b0;
      output_enable_ff <= OUT_EN_RST;
    end else begin
      event_ff         <= nxt_event;
      user_event_ff    <= |nxt_event;
      sticky_ff        <= nxt_sticky;
      if (mistake_evt) last_code_ff <= mis_num;
      // Lamp lights even when the bit is suppressed
      error_led_ff     <= mistake_evt | (error_led_ff & ~q_last);
      discard_line_ff  <= nxt_discard;
      tripped_ff       <= nxt_tripped;
      output_enable_ff <= nxt_out_en;
    end
  end

  // ----------------------------------------------------------------------
  // Answer register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= '0;
    end else begin
      resp_valid_ff <= any_query;
      if (any_query) resp_data_ff <= nxt_resp;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence mistake_open_s;
    mistake_evt && !line_end_stb;
  endsequence
  sequence line_goes_on_s;
    ##1 !line_end_stb;
  endsequence

  restart_load_a: assert property (restart |=>
    remain_ff == $past(holdoff_ticks_ff))
    else $error("holdoff not reloaded");
  holdoff_set_a: assert property (hs_ok |=>
    holdoff_ticks_ff == $past(set_ticks))
    else $error("holdoff setting not stored");
  reset_default_a: assert property ($rose(rst_n) |->
    trip_mode_ff == TRIP_OFF && holdoff_ticks_ff == HOLDOFF_RST_TICKS)
    else $error("wrong power-on defaults");
  holdoff_block_a: assert property (
    (run && !restart && !q_event && event_ff[EVT_TRP:EVT_VOLT] == '0 &&
     !tripped_ff) |=> event_ff[EVT_TRP:EVT_VOLT] == '0 && !tripped_ff)
    else $error("fault raised during holdoff");
  mistake_set_a: assert property (mis_set |=>
    event_ff[EVT_MIS] && sticky_ff[EVT_MIS] && error_led_ff)
    else $error("mistake not recorded");
  suppress_keep_a: assert property (
    (suppress_ff[EVT_MIS] && !suppress_set_stb && !event_ff[EVT_MIS]) |=>
    !event_ff[EVT_MIS])
    else $error("suppressed bit was set");
  discard_line_a: assert property (
    mistake_open_s ##0 line_goes_on_s |-> discard_line_ff)
    else $error("line not discarded after mistake");
  last_answer_a: assert property (
    (q_last && !q_hold) |=> resp_valid_ff &&
    resp_data_ff == {8'h00, $past(last_code_ff)})
    else $error("wrong last mistake answer");
  last_clear_a: assert property ((q_last && !mis_set) |=>
    !sticky_ff[EVT_MIS])
    else $error("sticky mistake bit not cleared");
  event_line_a: assert property (
    (event_ff != '0) |-> user_event_ff)
    else $error("event line low with events set");
  event_clear_a: assert property (
    (q_event && evt_set == '0) |=> event_ff == '0 && !user_event_ff)
    else $error("event query did not clear");
  trip_off_a: assert property (trip_now |=>
    !output_enable_ff && tripped_ff ##1 (!output_enable_ff || $past(rearm_go)))
    else $error("trip did not disable output");
  rearm_on_a: assert property ((rearm_go && !trip_now) |=>
    output_enable_ff && !tripped_ff)
    else $error("rearm did not restore output");
  sticky_live_a: assert property (volt_sync_ff |=>
    sticky_ff[EVT_VOLT])
    else $error("sticky bit missed live status");

endmodule

`default_nettype wire

/* inc/sfs_pkg.sv */
// Constants shared by the supply fault supervisor
//
// What this block does
// - Holdoff time programmable from zero to 32 s in 32 ms steps.
// - Holdoff time is 512 ms after power-on, 500 ms rounded up to 16 whole ticks.
// - Voltage, current, rearm, apply or output-on commands start holdoff.
// - Running holdoff keeps voltage, current and trip conditions from faulting.
// - Holdoff readback query returns the programmed holdoff time.
// - A programming mistake lights the error lamp and sets both mistake bits.
// - A suppressed mistake bit stays clear in the registers on a mistake.
// - After a mistake the rest of the command line is discarded.
// - Last-mistake query returns the newest mistake number, zero if none.
// - Last-mistake query clears the sticky mistake bit.
// - A fault on a condition sets its event register bit.
// - Suppressed event bits are never set.
// - Any set event bit drives the user event line.
// - Event query returns the sum of weights of set bits.
// - Event query clears the event bits and the user event line.
// - Trip mode accepts 0 off, 1 voltage trip, 2 current trip.
// - Entering the selected trip condition disables the output.
// - Tripped output stays off until the rearm command re-enables it.
// - Trip mode 1 disables the output on entering voltage regulation.
// - Trip mode is off after power-on.
// - Sticky status bit sets if its live bit was one since last read.

`default_nettype none

package sfs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_KHZ         = CLK_HZ / 1000;
  localparam int TICK_MS         = 32;
  localparam int TICK_CYCLES_DEF = CLK_KHZ * TICK_MS;
  localparam int PRESC_W         = 21;
  localparam int TICK_SHIFT      = 5;
  localparam int HOLD_W          = 10;
  localparam int MS_W            = 16;
  localparam logic [MS_W-1:0]   HOLDOFF_MAX_MS  = 16'h7D00;
  localparam int                HOLDOFF_DEF_MS  = 500;
  localparam logic [HOLD_W-1:0] HOLDOFF_RST_TICKS =
    HOLD_W'((HOLDOFF_DEF_MS + TICK_MS - 1) / TICK_MS);

  // ----------------------------------------------------------------------
  // Trip modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] TRIP_OFF = 2'h0;
  localparam logic [1:0] TRIP_VOLT = 2'h1;
  localparam logic [1:0] TRIP_CURR = 2'h2;
  localparam logic [1:0] TRIP_BAD = 2'h3;

  // ----------------------------------------------------------------------
  // Event and sticky status bit positions, weight is 2**position
  // ----------------------------------------------------------------------
  localparam int EVT_W   = 4;
  localparam int EVT_VOLT = 0;
  localparam int EVT_CURR = 1;
  localparam int EVT_TRP = 2;
  localparam int EVT_MIS = 3;
  localparam logic [EVT_W-1:0] SUPPRESS_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Mistake numbers raised inside the block, values arbitrary
  // ----------------------------------------------------------------------
  localparam logic [7:0] MISTAKE_NONE  = 8'h00;
  localparam logic [7:0] MISTAKE_RANGE = 8'h03;
  localparam logic [7:0] MISTAKE_MODE  = 8'h04;

  // Output state after reset
  localparam logic OUT_EN_RST = 1'b1;

endpackage

`default_nettype wire

/* verif/sfs_supply_model.sv */
// Power stage model that turns a requested regulation mode into live pins
`timescale 1ns/10ps
`default_nettype none

module sfs_supply_model
  import sfs_pkg::*;
(
  input  wire logic       output_enable,
  input  wire logic [1:0] reg_mode,
  output logic            volt_live,
  output logic            curr_live
);
  // ----------------------------------------------------------------------
  // Regulation flags
  // ----------------------------------------------------------------------
  // A disabled output regulates nothing, so both flags drop with it
  assign volt_live = output_enable & (reg_mode == TRIP_VOLT);
  assign curr_live = output_enable & (reg_mode == TRIP_CURR);
endmodule
`default_nettype wire

/* verif/supply_fault_supervisor_bench.sv */
// Self-checking bench for the supply fault supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) chk(32'(a), 32'(b))

module supply_fault_supervisor_bench
  import sfs_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int S_HSET = 0, S_HRD = 1, S_VOLT = 2, S_CURR = 3, S_APPLY = 4;
  localparam int S_REARM = 5, S_ON = 6, S_OFF = 7, S_TRIP = 8, S_SUPP = 9;
  localparam int S_MIS = 10, S_END = 11, S_STKY = 12, S_LAST = 13;
  localparam int S_EVT = 14;
  logic            mclk, rst_n;
  logic [14:0]     stb;
  logic [MS_W-1:0] hval, rd;
  logic [1:0]      tval, pmode;
  logic [3:0]      sval;
  logic [7:0]      mcode;
  logic            v_live, i_live, rv, led, uev, oe, trp, dsc, hact;
  logic [1:0]      tmode;
  int              bad_count, checked, n;

  sfs_supervisor #(.TICK_CYCLES(8)) uut (
    .mclk(mclk), .rst_n(rst_n), .holdoff_set_stb(stb[S_HSET]),
    .holdoff_set_val(hval), .holdoff_readback_query(stb[S_HRD]),
    .voltage_program_cmd(stb[S_VOLT]), .current_program_cmd(stb[S_CURR]),
    .sync_apply_cmd(stb[S_APPLY]), .rearm_cmd(stb[S_REARM]),
    .output_on_cmd(stb[S_ON]), .output_off_cmd(stb[S_OFF]),
    .trip_mode_set_stb(stb[S_TRIP]), .trip_mode_val(tval),
    .suppress_set_stb(stb[S_SUPP]), .suppress_val(sval),
    .mistake_stb(stb[S_MIS]), .mistake_code(mcode),
    .line_end_stb(stb[S_END]), .sticky_status_query(stb[S_STKY]),
    .last_mistake_query(stb[S_LAST]), .event_query(stb[S_EVT]),
    .constant_voltage_state(v_live), .constant_current_state(i_live),
    .resp_valid_ff(rv), .resp_data_ff(rd), .error_led_ff(led),
    .user_event_ff(uev), .output_enable_ff(oe), .tripped_ff(trp),
    .discard_line_ff(dsc), .trip_mode_ff(tmode), .holdoff_active_ff(hact));

  sfs_supply_model model (.output_enable(oe), .reg_mode(pmode),
    .volt_live(v_live), .curr_live(i_live));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs move one ns after the edge so sampling is never racy
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(input int i);
    stb[i] = 1'b1;
    cyc(1);
    stb[i] = 1'b0;
  endtask

  // Answer lasts one cycle only, so it is checked right after the edge
  task automatic qry(input int i);
    pulse(i);
    `CHK(rv, 1);
    cyc(1);
  endtask

  task automatic wait_idle();
    n = 0;
    while (hact !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      final_report();
    end
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Cuts a hang short well inside the cycle budget
  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, stb, hval, tval, pmode, sval, mcode} = '0;
    bad_count = 0;
    checked = 0;
    cyc(5);
    rst_n = 1'b1;
    `CHK(tmode, 0);
    `CHK({oe, hact}, 2'h2);
    qry(S_HRD);
    `CHK(rd, 512);
    qry(S_LAST);
    `CHK(rd, 0);
    done("reset");
    // Holdoff of 128 ms is four ticks of eight cycles
    hval = 16'h0080;
    pulse(S_HSET);
    qry(S_HRD);
    `CHK(rd, 128);
    pulse(S_OFF);
    `CHK(oe, 0);
    for (int i = S_VOLT; i <= S_ON; i++) begin
      pulse(i);
      `CHK(hact, 1);
      wait_idle();
      `CHK(n >= 24 && n <= 42, 1);
    end
    `CHK(oe, 1);
    // A second command mid-interval must push the end out
    pulse(S_VOLT);
    cyc(20);
    pulse(S_CURR);
    wait_idle();
    `CHK(n >= 24 && n <= 42, 1);
    done("holdoff");
    pulse(S_CURR);
    pmode = 2'h2;
    cyc(5);
    qry(S_EVT);
    `CHK(rd, 0);
    wait_idle();
    cyc(3);
    pmode = 2'h0;
    cyc(4);
    `CHK(uev, 1);
    qry(S_EVT);
    `CHK(rd, 2);
    `CHK(uev, 0);
    qry(S_EVT);
    `CHK(rd, 0);
    done("events");
    hval = 16'h0000;
    pulse(S_HSET);
    qry(S_HRD);
    `CHK(rd, 0);
    qry(S_STKY);
    pmode = 2'h1;
    cyc(4);
    pmode = 2'h0;
    cyc(4);
    qry(S_STKY);
    `CHK(rd, 1);
    qry(S_EVT);
    `CHK(rd, 1);
    sval = 4'h2;
    pulse(S_SUPP);
    pmode = 2'h2;
    cyc(4);
    pmode = 2'h0;
    cyc(4);
    `CHK(uev, 0);
    qry(S_EVT);
    `CHK(rd, 0);
    done("sticky_suppress");
    // Enter the selected trip state from the other regulation mode
    for (int m = 1; m <= 2; m++) begin
      tval = 2'(m);
      pulse(S_TRIP);
      `CHK(tmode, m);
      pmode = 2'(3 - m);
      cyc(5);
      `CHK(oe, 1);
      pmode = 2'(m);
      cyc(5);
      `CHK({oe, trp}, 2'h1);
      pulse(S_ON);
      `CHK(oe, 0);
      pmode = 2'h0;
      cyc(3);
      pulse(S_REARM);
      `CHK({oe, trp}, 2'h2);
    end
    tval = 2'h3;
    pulse(S_TRIP);
    `CHK(tmode, 2);
    pulse(S_END);
    cyc(1);
    qry(S_LAST);
    `CHK(rd, 4);
    tval = 2'h0;
    pulse(S_TRIP);
    `CHK(tmode, 0);
    done("trip");
    qry(S_EVT);
    qry(S_STKY);
    mcode = 8'h21;
    pulse(S_MIS);
    `CHK({led, dsc}, 2'h3);
    pulse(S_HRD);
    `CHK(rv, 0);
    pulse(S_END);
    cyc(1);
    qry(S_EVT);
    `CHK(rd, 8);
    qry(S_LAST);
    `CHK(rd, 8'h21);
    `CHK(led, 0);
    qry(S_STKY);
    `CHK(rd, 0);
    sval = 4'h8;
    pulse(S_SUPP);
    pulse(S_MIS);
    pulse(S_END);
    cyc(1);
    qry(S_EVT);
    `CHK(rd, 0);
    qry(S_STKY);
    `CHK(rd, 0);
    done("mistake");
    hval = 16'h7D01;
    pulse(S_HSET);
    pulse(S_END);
    cyc(1);
    qry(S_LAST);
    `CHK(rd, 3);
    hval = 16'h7D00;
    pulse(S_HSET);
    qry(S_HRD);
    `CHK(rd, 16'h7D00);
    done("range");
    final_report();
  end
endmodule
`default_nettype wire
